// >>> shared/facd_defs.vh
// Functional notes
// - Configure opcode 13H, then zero byte, flags/threshold byte, precomp track byte.
// - Dump opcode 0EH, no parameters, internal registers queued for result.
// - Dump returns ten bytes in fixed order, cylinders first, precomp last.
// - Dump byte seven is sector count after format, end-of-track after read/write.
// - Dump drive select bits are internal, never drive external select pins.
// - Read identifier keeps the first error-free identifier field of the cylinder.
// - Read identifier returns status 0,1,2 then cylinder, head, sector, size.
// - Perpendicular mode opcode 12H plus byte whose bit 7 gates the update.
// - Unknown opcode is a no-op: standby and one result byte 80H.
// - Lock opcode bit 7 new value, bits 6-0 0010100; result has lock in bit 4.
// - With implied seek enabled, data transfers seek before moving data.
`ifndef FACD_DEFS_VH
`define FACD_DEFS_VH
`define FACD_OP_CONFIG      8'h13
`define FACD_OP_DUMP        8'h0E
`define FACD_OP_PERP        8'h12
`define FACD_OP_LOCK_LO     7'h14
`define FACD_OP_RSEEK_LO    6'h0F
`define FACD_OP_RDID_LO     6'h0A
`define FACD_ST0_INVALID    8'h80
`define FACD_DUMP_LEN       4'hA
`define FACD_RDID_LEN       4'h7
`define FACD_CFG_PARAMS     2'h3
`define FACD_SEEK_PARAMS    2'h2
`define FACD_RDID_PARAMS    2'h1
`define FACD_PERP_PARAMS    2'h1
`define FACD_CFG_EIS_BIT    6
`define FACD_CFG_FIFO_DISABLE_FLAG_BIT  5
`define FACD_CFG_POLL_BIT   4
`define FACD_LOCK_RES_BIT   4
`define FACD_PERP_OW_BIT    7
`define FACD_CFG_RST        8'h20
`define FACD_PRECOMP_START_TRACK_RST     8'h00
`endif

// >>> core/facd_result_mem.v
`timescale 1ns/1ps
`default_nettype none
// Small result byte store, read data registered
module facd_result_mem (
	input  wire       clk_sys,  // Core clock
	input  wire       we,       // Write enable
	input  wire [3:0] waddr,    // Write index
	input  wire [7:0] wdata,    // Write byte
	input  wire [3:0] raddr,    // Read index
	output reg  [7:0] rdata     // Registered read byte
);
	reg [7:0] mem [0:15];

	// No reset: contents only read after being written
	always @(posedge clk_sys) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // facd_result_mem
`default_nettype wire

// >>> core/facd_cmd_decoder.v
`timescale 1ns/1ps
`default_nettype none
`include "facd_defs.vh"
// Auxiliary command interpreter: command, execution and result phases
module facd_cmd_decoder (
	input  wire       clk_sys,          // Core clock, 40 MHz
	input  wire       rst,              // Async reset, active high
	input  wire       cmd_wr,           // Host writes a byte
	input  wire [7:0] cmd_wdata,        // Byte written
	input  wire       res_rd,           // Host reads a result byte
	output reg  [7:0] res_rdata,        // Result byte, valid cycle after res_rd
	output wire       res_avail,        // Result bytes pending
	output wire       cmd_busy,         // Not idle
	input  wire [7:0] step_rate_head_unload, // Step rate and unload byte
	input  wire [7:0] head_load_nondma, // Head load and non-DMA byte
	input  wire [7:0] sector_count,     // Last format sector count
	input  wire [7:0] end_of_track_sector, // Last read/write end of track
	input  wire       last_was_format,  // Previous command was format
	input  wire [1:0] gap_write_gate_flag,        // Gap and write gate flags
	input  wire [3:0] dsel_internal_in, // Internal drive select bits
	output reg        seek_start,       // Relative seek request pulse
	output reg        seek_dir,         // Step direction
	output reg  [7:0] relative_cylinder_count, // Step count
	input  wire       seek_done,        // Seek finished pulse
	input  wire [7:0] seek_new_cyl,     // Cylinder after seek
	output reg        rdid_start,       // Read identifier request pulse
	output reg        double_density_select, // Density for read identifier
	output reg        head_select,      // Head for current command
	output reg  [1:0] drive_num,        // Drive for current command
	input  wire       id_valid,         // Error-free identifier seen
	input  wire [31:0] id_field,        // Cylinder, head, sector, size
	input  wire [23:0] rdid_status,     // Status bytes 0,1,2
	input  wire       rdid_done,        // Read identifier finished pulse
	input  wire       xfer_req,         // Data transfer command start pulse
	output wire       xfer_seek_first,  // Transfer must seek first
	output reg        implied_seek_enable, // Configured implied seek
	output reg        fifo_disable_flag,   // Configured FIFO disable
	output reg        poll_disable,     // Configured polling disable
	output reg  [3:0] fifo_threshold,   // Configured FIFO threshold
	output reg  [7:0] precomp_start_track, // Configured precomp track
	output reg        lock_q,           // Lock state
	output reg  [7:0] perp_setting,     // Perpendicular setting bits
	output reg        standby_req,      // Invalid opcode standby pulse
	output reg        irq,              // Level interrupt
	input  wire       irq_clr_wr,       // Write-one-to-clear strobe
	input  wire [1:0] irq_clr_data,     // Bits to clear
	input  wire [1:0] irq_mask,         // Interrupt mask, 1 enables
	output reg  [1:0] irq_status        // Sticky: 0 seek done, 1 read id done
);
	localparam S_IDLE = 3'd0;
	localparam S_PARAM = 3'd1;
	localparam S_EXEC = 3'd2;
	localparam S_LOAD = 3'd3;
	localparam S_RESULT = 3'd4;

	localparam C_NONE = 3'd0;
	localparam C_CFG = 3'd1;
	localparam C_SEEK = 3'd2;
	localparam C_RDID = 3'd3;
	localparam C_PERP = 3'd4;
	localparam C_LOCK = 3'd5;

	// Configuration reset image, split into fields below
	localparam [7:0] CFG_RST = `FACD_CFG_RST;

	reg [2:0]  state_q;
	reg [2:0]  cmd_q;
	reg [1:0]  pcnt_q;
	reg [1:0]  pidx_q;
	reg [3:0]  widx_q;
	reg [3:0]  rlen_q;
	reg [3:0]  ridx_q;
	wire [3:0] mem_raddr;
	reg [7:0]  cyl_q [0:3];
	reg [31:0] id_q;
	reg        id_got_q;
	reg        mem_we;
	reg [3:0]  mem_waddr;
	reg [7:0]  mem_wdata;
	wire [7:0] mem_rdata;
	integer    i;

	// Param count per opcode; zero count means no parameters
	function [4:0] op_decode;
		input [7:0] op;
		begin
			if (op == `FACD_OP_CONFIG) begin
				op_decode = {C_CFG, `FACD_CFG_PARAMS};
			end else if (op[7] && op[5:0] == `FACD_OP_RSEEK_LO) begin
				op_decode = {C_SEEK, `FACD_SEEK_PARAMS};
			end else if (!op[7] && op[5:0] == `FACD_OP_RDID_LO) begin
				op_decode = {C_RDID, `FACD_RDID_PARAMS};
			end else if (op == `FACD_OP_PERP) begin
				op_decode = {C_PERP, `FACD_PERP_PARAMS};
			end else begin
				op_decode = {C_NONE, 2'd0};
			end
		end
	endfunction

	// Dump byte by index
	function [7:0] dump_byte;
		input [3:0] idx;
		begin
			case (idx)
				4'd0: dump_byte = cyl_q[0];
				4'd1: dump_byte = cyl_q[1];
				4'd2: dump_byte = cyl_q[2];
				4'd3: dump_byte = cyl_q[3];
				4'd4: dump_byte = step_rate_head_unload;
				4'd5: dump_byte = head_load_nondma;
				4'd6: dump_byte = last_was_format ? sector_count : end_of_track_sector;
				4'd7: dump_byte = {lock_q, 1'b0, dsel_internal_in, gap_write_gate_flag};
				4'd8: dump_byte = {1'b0, implied_seek_enable, fifo_disable_flag,
					poll_disable, fifo_threshold};
				default: dump_byte = precomp_start_track;
			endcase
		end
	endfunction

	// Read identifier result byte by index
	function [7:0] rdid_byte;
		input [3:0] idx;
		begin
			case (idx)
				4'd0: rdid_byte = rdid_status[23:16];
				4'd1: rdid_byte = rdid_status[15:8];
				4'd2: rdid_byte = rdid_status[7:0];
				4'd3: rdid_byte = id_q[31:24];
				4'd4: rdid_byte = id_q[23:16];
				4'd5: rdid_byte = id_q[15:8];
				default: rdid_byte = id_q[7:0];
			endcase
		end
	endfunction

	facd_result_mem u_mem (
		.clk_sys (clk_sys),
		.we      (mem_we),
		.waddr   (mem_waddr),
		.wdata   (mem_wdata),
		.raddr   (mem_raddr),
		.rdata   (mem_rdata)
	);

	assign res_avail = (state_q == S_RESULT);
	assign cmd_busy = (state_q != S_IDLE);
	// Read one ahead on a strobe, so back-to-back reads never see a stale byte
	assign mem_raddr = (state_q == S_RESULT && res_rd) ? ridx_q + 4'd1 : ridx_q;
	assign xfer_seek_first = xfer_req & implied_seek_enable;

	// Result memory fill during load phase; snapshot taken here
	always @* begin
		mem_we = (state_q == S_LOAD);
		mem_waddr = widx_q;
		if (cmd_q == C_RDID) begin
			mem_wdata = rdid_byte(widx_q);
		end else begin
			mem_wdata = dump_byte(widx_q);
		end
	end

	// Sticky events; a new event wins over a same-cycle clear
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_status <= 2'h0;
			irq <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~({2{irq_clr_wr}} & irq_clr_data))
				| {rdid_done, seek_done};
			irq <= |(irq_status & irq_mask);
		end
	end

	// Main sequencer
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= S_IDLE;
			cmd_q <= C_NONE;
			pcnt_q <= 2'd0;
			pidx_q <= 2'd0;
			widx_q <= 4'd0;
			rlen_q <= 4'd0;
			ridx_q <= 4'd0;
			res_rdata <= 8'h00;
			for (i = 0; i < 4; i = i + 1) begin
				cyl_q[i] <= 8'h00;
			end
			id_q <= 32'h0;
			id_got_q <= 1'b0;
			seek_start <= 1'b0;
			seek_dir <= 1'b0;
			relative_cylinder_count <= 8'h00;
			rdid_start <= 1'b0;
			double_density_select <= 1'b0;
			head_select <= 1'b0;
			drive_num <= 2'd0;
			implied_seek_enable <= CFG_RST[`FACD_CFG_EIS_BIT];
			fifo_disable_flag <= CFG_RST[`FACD_CFG_FIFO_DISABLE_FLAG_BIT];
			poll_disable <= CFG_RST[`FACD_CFG_POLL_BIT];
			fifo_threshold <= CFG_RST[3:0];
			precomp_start_track <= `FACD_PRECOMP_START_TRACK_RST;
			lock_q <= 1'b0;
			perp_setting <= 8'h00;
			standby_req <= 1'b0;
		end else begin
			seek_start <= 1'b0;
			rdid_start <= 1'b0;
			standby_req <= 1'b0;
			case (state_q)
				S_IDLE: begin
					ridx_q <= 4'd0;
					widx_q <= 4'd0;
					pidx_q <= 2'd0;
					if (cmd_wr) begin
						{cmd_q, pcnt_q} <= op_decode(cmd_wdata);
						if (cmd_wdata == `FACD_OP_DUMP) begin
							rlen_q <= `FACD_DUMP_LEN;
							state_q <= S_LOAD;
						end else if (cmd_wdata[6:0] == `FACD_OP_LOCK_LO) begin
							lock_q <= cmd_wdata[7];
							widx_q <= 4'd0;
							rlen_q <= 4'd1;
							state_q <= S_RESULT;
						end else if (op_decode(cmd_wdata) == 5'd0) begin
							standby_req <= 1'b1;
							rlen_q <= 4'd1;
							state_q <= S_RESULT;
						end else begin
							if (cmd_wdata[7] && cmd_wdata[5:0] == `FACD_OP_RSEEK_LO) begin
								seek_dir <= cmd_wdata[6];
							end
							if (!cmd_wdata[7] && cmd_wdata[5:0] == `FACD_OP_RDID_LO) begin
								double_density_select <= cmd_wdata[6];
							end
							state_q <= S_PARAM;
						end
						if (cmd_wdata[6:0] == `FACD_OP_LOCK_LO) begin
							cmd_q <= C_LOCK;
						end
					end
				end
				S_PARAM: begin
					if (cmd_wr) begin
						pidx_q <= pidx_q + 2'd1;
						if (pidx_q == 2'd0 && (cmd_q == C_SEEK || cmd_q == C_RDID)) begin
							head_select <= cmd_wdata[2];
							drive_num <= cmd_wdata[1:0];
						end
						if (cmd_q == C_CFG && pidx_q == 2'd1) begin
							implied_seek_enable <= cmd_wdata[`FACD_CFG_EIS_BIT];
							fifo_disable_flag <= cmd_wdata[`FACD_CFG_FIFO_DISABLE_FLAG_BIT];
							poll_disable <= cmd_wdata[`FACD_CFG_POLL_BIT];
							fifo_threshold <= cmd_wdata[3:0];
						end
						if (cmd_q == C_CFG && pidx_q == 2'd2) begin
							precomp_start_track <= cmd_wdata;
						end
						if (cmd_q == C_SEEK && pidx_q == 2'd1) begin
							relative_cylinder_count <= cmd_wdata;
						end
						if (cmd_q == C_PERP && cmd_wdata[`FACD_PERP_OW_BIT]) begin
							perp_setting <= {1'b0, cmd_wdata[6:0]};
						end
						if (pidx_q + 2'd1 == pcnt_q) begin
							if (cmd_q == C_SEEK) begin
								seek_start <= 1'b1;
								state_q <= S_EXEC;
							end else if (cmd_q == C_RDID) begin
								rdid_start <= 1'b1;
								id_got_q <= 1'b0;
								state_q <= S_EXEC;
							end else begin
								state_q <= S_IDLE;
							end
						end
					end
				end
				S_EXEC: begin
					if (cmd_q == C_RDID && id_valid && !id_got_q) begin
						id_q <= id_field;
						id_got_q <= 1'b1;
					end
					if (cmd_q == C_SEEK && seek_done) begin
						cyl_q[drive_num] <= seek_new_cyl;
						state_q <= S_IDLE;
					end
					if (cmd_q == C_RDID && rdid_done) begin
						rlen_q <= `FACD_RDID_LEN;
						state_q <= S_LOAD;
					end
				end
				S_LOAD: begin
					widx_q <= widx_q + 4'd1;
					if (widx_q + 4'd1 == rlen_q) begin
						state_q <= S_RESULT;
					end
				end
				S_RESULT: begin
					if (res_rd) begin
						ridx_q <= ridx_q + 4'd1;
						if (rlen_q == 4'd1) begin
							// Single fixed byte paths bypass the memory
							if (cmd_q == C_LOCK) begin
								res_rdata <= lock_q ? (8'h01 << `FACD_LOCK_RES_BIT) : 8'h00;
							end else begin
								res_rdata <= `FACD_ST0_INVALID;
							end
						end else begin
							// Memory output already holds the byte at ridx_q
							res_rdata <= mem_rdata;
						end
						if (ridx_q + 4'd1 == rlen_q) begin
							state_q <= S_IDLE;
						end
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end
endmodule // facd_cmd_decoder
`default_nettype wire

// >>> tb/facd_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "facd_defs.vh"
// Watches opcode decode, launches and interrupt
module facd_checker (
	input wire logic       clk_sys,                 // Clock
	input wire logic       rst,                     // Reset
	input wire logic       cmd_wr,                  // Byte strobe
	input wire logic [7:0] cmd_wdata,               // Byte
	input wire logic       cmd_busy,                // Not idle
	input wire logic       res_avail,               // Results
	input wire logic       seek_start,              // Seek pulse
	input wire logic [7:0] relative_cylinder_count, // Steps
	input wire logic       rdid_start,              // Read id pulse
	input wire logic       head_select,             // Head
	input wire logic [1:0] drive_num,               // Drive
	input wire logic       seek_done,               // Seek end
	input wire logic       xfer_req,                // Transfer start
	input wire logic       xfer_seek_first,         // Seek first
	input wire logic       implied_seek_enable,     // Implied seek
	input wire logic       lock_q,                  // Lock
	input wire logic       standby_req,             // Standby pulse
	input wire logic       irq,                     // Interrupt
	input wire logic [1:0] irq_mask,                // Mask
	input wire logic [1:0] irq_status               // Sticky bits
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Opcode taken in idle, and whether it is known
	wire logic new_op = cmd_wr && !cmd_busy;
	wire logic op_ok = cmd_wdata == `FACD_OP_CONFIG || cmd_wdata == `FACD_OP_DUMP
		|| cmd_wdata == `FACD_OP_PERP || cmd_wdata[6:0] == `FACD_OP_LOCK_LO
		|| (cmd_wdata[7] && cmd_wdata[5:0] == `FACD_OP_RSEEK_LO)
		|| (!cmd_wdata[7] && cmd_wdata[5:0] == `FACD_OP_RDID_LO);
	xfer_seek_a: assert property (xfer_seek_first == (xfer_req && implied_seek_enable))
		else $error("seek-first flag wrong");
	lock_update_a: assert property (new_op && cmd_wdata[6:0] == `FACD_OP_LOCK_LO
		|=> lock_q == $past(cmd_wdata[7])) else $error("lock not taken");
	bad_standby_a: assert property (new_op && !op_ok |=> standby_req ##1 !standby_req)
		else $error("no standby pulse");
	seek_launch_a: assert property (seek_start |-> $past(cmd_wr)
		&& relative_cylinder_count == $past(cmd_wdata)) else $error("seek launch wrong");
	rdid_launch_a: assert property (rdid_start |-> $past(cmd_wr)
		&& head_select == $past(cmd_wdata[2]) && drive_num == $past(cmd_wdata[1:0]))
		else $error("read id launch wrong");
	dump_load_a: assert property (new_op && cmd_wdata == `FACD_OP_DUMP
		|=> !res_avail ##[1:12] res_avail) else $error("dump results late");
	irq_level_a: assert property (irq == |($past(irq_status) & $past(irq_mask)))
		else $error("irq level wrong");
	seek_sticky_a: assert property (seek_done |=> irq_status[0])
		else $error("seek status not set");
endmodule // facd_checker
bind facd_cmd_decoder facd_checker chk_u (.clk_sys, .rst, .cmd_wr, .cmd_wdata, .cmd_busy,
	.res_avail, .seek_start, .relative_cylinder_count, .rdid_start, .head_select, .drive_num,
	.seek_done, .xfer_req, .xfer_seek_first, .implied_seek_enable, .lock_q, .standby_req,
	.irq, .irq_mask, .irq_status);
`default_nettype wire

// >>> tb/facd_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// Drive side: answers seeks and read id requests
module facd_drive_model #(
	parameter int          LAT  = 3,            // Seek answer delay
	parameter logic [7:0]  CYL  = 8'h37,        // Cylinder reached
	parameter logic [31:0] GOOD = 32'h25010702  // First good id
) (
	input  wire logic        clk_sys,      // Clock
	input  wire logic        rst,          // Reset
	input  wire logic        seek_start,   // Seek pulse
	input  wire logic        rdid_start,   // Read id pulse
	output wire logic        seek_done,    // Seek end
	output wire logic [7:0]  seek_new_cyl, // New cylinder
	output wire logic        id_valid,     // Good id seen
	output wire logic [31:0] id_field,     // Id bytes
	output wire logic [23:0] rdid_status,  // Status bytes
	output wire logic        rdid_done     // Read id end
);
	logic [7:0] sk_q;
	logic [2:0] ph_q;
	// Seek countdown and id phases: bad, good, later good, done
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sk_q <= 8'h00;
			ph_q <= 3'h0;
		end else begin
			sk_q <= seek_start ? LAT[7:0] : (sk_q != 8'h00 ? sk_q - 8'h01 : 8'h00);
			ph_q <= rdid_start ? 3'h1 : (ph_q != 3'h0 && ph_q < 3'h4 ? ph_q + 3'h1 : 3'h0);
		end
	end
	// seek answer, cylinder shown only with done
	assign seek_done = sk_q == 8'h01;
	assign seek_new_cyl = seek_done ? CYL : ~CYL;
	// only the first good field is the one to keep
	assign id_valid = ph_q == 3'h2 || ph_q == 3'h3;
	assign id_field = ph_q == 3'h2 ? GOOD : ~GOOD;
	assign rdid_done = ph_q == 3'h4;
	assign rdid_status = 24'h040001;
endmodule // facd_drive_model
`default_nettype wire

// >>> tb/facd_cmd_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "facd_defs.vh"
// Host bench: command bytes in, result bytes out
module facd_cmd_decoder_tb_top;
	localparam logic [7:0] SRUH = 8'hA5, HLND = 8'h3C, SC = 8'h12, END_OF_TRACK_SECTOR = 8'h09;
	localparam logic [1:0] GAPW = 2'b10;
	logic clk_sys = 1'b0, rst = 1'b1, cmd_wr = 1'b0, res_rd = 1'b0, last_was_format = 1'b0;
	logic xfer_req = 1'b0, irq_clr_wr = 1'b0;
	logic [7:0] cmd_wdata = 8'h00;
	logic [3:0] dsel_internal_in = 4'h6;
	logic [1:0] irq_clr_data = 2'h0, irq_mask = 2'h0;
	wire [7:0] res_rdata, relative_cylinder_count, precomp_start_track, perp_setting, seek_new_cyl;
	wire res_avail, cmd_busy, seek_start, seek_dir, rdid_start, double_density_select;
	wire head_select, xfer_seek_first, implied_seek_enable, fifo_disable_flag, poll_disable;
	wire lock_q, standby_req, irq, seek_done, id_valid, rdid_done;
	wire [1:0] drive_num, irq_status;
	wire [3:0] fifo_threshold;
	wire [31:0] id_field;
	wire [23:0] rdid_status;
	int bad_count = 0;
	int checked = 0;
	facd_cmd_decoder dut_u (.clk_sys, .rst, .cmd_wr, .cmd_wdata, .res_rd, .res_rdata, .res_avail,
		.cmd_busy, .step_rate_head_unload(SRUH), .head_load_nondma(HLND), .sector_count(SC),
		.end_of_track_sector(END_OF_TRACK_SECTOR), .last_was_format, .gap_write_gate_flag(GAPW), .dsel_internal_in,
		.seek_start, .seek_dir, .relative_cylinder_count, .seek_done, .seek_new_cyl, .rdid_start,
		.double_density_select, .head_select, .drive_num, .id_valid, .id_field, .rdid_status,
		.rdid_done, .xfer_req, .xfer_seek_first, .implied_seek_enable, .fifo_disable_flag,
		.poll_disable, .fifo_threshold, .precomp_start_track, .lock_q, .perp_setting,
		.standby_req, .irq, .irq_clr_wr, .irq_clr_data, .irq_mask, .irq_status);
	facd_drive_model drv_u (.clk_sys, .rst, .seek_start, .rdid_start, .seek_done,
		.seek_new_cyl, .id_valid, .id_field, .rdid_status, .rdid_done);
	// Clock, 25 ns period
	always #12.5 clk_sys = ~clk_sys;
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One byte to the command port, a free cycle after it
	task automatic wr(input logic [7:0] b);
		@(posedge clk_sys);
		cmd_wr <= 1'b1;
		cmd_wdata <= b;
		@(posedge clk_sys);
		cmd_wr <= 1'b0;
	endtask
	// Read strobe, data sampled in the following cycle
	task automatic rd_chk(input logic [7:0] exp);
		@(posedge clk_sys);
		res_rd <= 1'b1;
		@(posedge clk_sys);
		res_rd <= 1'b0;
		#1 chk(res_rdata, exp);
	endtask
	// Two reads with no gap, each byte checked in the cycle after its strobe
	task automatic rd2_chk(input logic [7:0] exp0, input logic [7:0] exp1);
		@(posedge clk_sys);
		res_rd <= 1'b1;
		@(posedge clk_sys);
		#1 chk(res_rdata, exp0);
		@(posedge clk_sys);
		res_rd <= 1'b0;
		#1 chk(res_rdata, exp1);
	endtask
	// Bounded wait on result phase (sel 1) or busy (sel 0)
	task automatic wait_on(input bit sel, input logic lvl);
		int n;
		#1 n = 0;
		while ((sel ? res_avail : cmd_busy) !== lvl && n < 80) begin
			@(posedge clk_sys);
			#1 n++;
		end
		chk(sel ? res_avail : cmd_busy, lvl);
	endtask
	task automatic t_config();
		wr(`FACD_OP_CONFIG);
		wr(8'h00);
		wr(8'h55);
		wr(8'h4B);
		wait_on(0, 1'b0);
		chk({implied_seek_enable, fifo_disable_flag, poll_disable, fifo_threshold}, 8'h55);
		chk(precomp_start_track, 8'h4B);
		@(posedge clk_sys);
		xfer_req <= 1'b1;
		#1 chk(xfer_seek_first, 1'b1);
		@(posedge clk_sys);
		xfer_req <= 1'b0;
	endtask
	task automatic t_seek();
		wr(8'hCF);
		wr(8'h06);
		wr(8'h25);
		wait_on(0, 1'b0);
		chk({seek_dir, head_select, drive_num, relative_cylinder_count}, 12'hE25);
		chk({irq_status, irq}, 3'b010);
		irq_mask <= 2'b01;
		repeat (2) @(posedge clk_sys);
		#1 chk(irq, 1'b1);
		irq_clr_wr <= 1'b1;
		irq_clr_data <= 2'b01;
		@(posedge clk_sys);
		irq_clr_wr <= 1'b0;
		@(posedge clk_sys);
		#1 chk({irq_status, irq}, 3'b000);
	endtask
	task automatic t_rdid();
		logic [55:0] exp;
		exp = {24'h040001, 32'h25010702};
		wr(8'h4A);
		wr(8'h01);
		#1 chk({double_density_select, head_select, drive_num}, 4'h9);
		wait_on(1, 1'b1);
		for (int i = 6; i >= 0; i--) rd_chk(exp[i*8 +: 8]);
		wait_on(0, 1'b0);
	endtask
	// Lock both ways, each followed by an unknown opcode with a refused byte in the result phase
	task automatic t_lock_bad();
		for (int i = 0; i < 2; i++) begin
			wr({i[0], 7'h14});
			wait_on(1, 1'b1);
			rd_chk({3'h0, i[0], 4'h0});
			chk(lock_q, i[0]);
			wait_on(0, 1'b0);
			wr(i ? 8'hFF : 8'h1F);
			wait_on(1, 1'b1);
			wr(`FACD_OP_DUMP);
			rd_chk(`FACD_ST0_INVALID);
			wait_on(0, 1'b0);
		end
		wr(`FACD_OP_PERP);
		wr(8'h03);
		wait_on(0, 1'b0);
		chk(perp_setting, 8'h00);
		wr(`FACD_OP_PERP);
		wr(8'h83);
		wait_on(0, 1'b0);
		chk(perp_setting, 8'h03);
	endtask
	task automatic t_dump();
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_sys);
			last_was_format <= i[0];
			dsel_internal_in <= i ? 4'h9 : 4'h6;
			wr(`FACD_OP_DUMP);
			wait_on(1, 1'b1);
			rd2_chk(8'h00, 8'h00);
			rd2_chk(8'h37, 8'h00);
			rd_chk(SRUH);
			rd_chk(HLND);
			rd_chk(i ? SC : END_OF_TRACK_SECTOR);
			rd_chk({2'b10, dsel_internal_in, GAPW});
			rd_chk(8'h55);
			rd_chk(8'h4B);
			wait_on(0, 1'b0);
		end
	endtask
	// Main sequence after a four cycle reset
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		#1 chk({fifo_disable_flag, implied_seek_enable, lock_q, irq}, 4'h8);
		t_config();
		t_seek();
		t_rdid();
		t_lock_bad();
		t_dump();
		stop_test();
	end
	// Watchdog, far beyond the few hundred cycles needed
	initial begin
		#1000000;
		bad_count++;
		stop_test();
	end
endmodule // facd_cmd_decoder_tb_top
`default_nettype wire
